// ===== src/bvc_top.sv
/*
  Buck regulator enable, mode and voltage-select control with an APB register file.
  Assumes RST is the power-on reset, pins other than EN and VOLTAGE_SELECT_PIN are synchronous,
  SW_CYCLE marks each switching cycle and ILIM_HIT is valid with it.
*/
// The implementer's own choices: the APB register port and the address map.
`timescale 1ns/1ps
`include "bvc_defines.svh"

// Notes on behaviour
// - Enable pin low forces shutdown regardless of select pin or software bits.
// - Register port works with enable low whenever supply is above lockout.
// - Registers keep their contents across enable-pin shutdown.
// - Power-on reset returns every register, both voltage slots too, to default.
// - Bleed bit set and pin low or selected enable clear connects discharge load.
// - Enable rising while selected software enable set starts soft-start.
// - Build option adds 5 ms delay from enable high to soft-start.
// - Soft-start ramps reference slowly with synchronous rectification off.
// - Sixteen consecutive current-limit cycles: shut down, tri-state, retry after 1700 us.
// - Both software enables reset to one so the regulator starts after reset.
// - Select pin low picks low slot and auto; high picks high slot and forced PWM, with reset mode bits.
// - PFM permission follows control mode bits combined with select pin level.
// - Target voltage is 0.35 V plus code times 6.25 mV.
// - Select pin chooses low or high voltage slot, following every toggle.
module bvc_top
  import bvc_pkg::*;
#(
  parameter int          AW           = 8,
  parameter bit          USE_EN_DELAY = 1'b0,
  parameter int          EN_DELAY_CYC = `BVC_EN_DELAY_CYC,
  parameter int          RETRY_CYC    = `BVC_RETRY_CYC,
  parameter logic [6:0]  VCODE_RST    = 7'h00,
  parameter logic [7:0]  ID1_VAL      = 8'h5A,  // Arbitrary identity value
  parameter logic [7:0]  ID2_VAL      = 8'h01   // Arbitrary revision value
) (
  input  wire logic          CORE_CLK,
  input  wire logic          RST,
  input  wire logic          PSEL,
  input  wire logic          PENABLE,
  input  wire logic          PWRITE,
  input  wire logic [AW-1:0] PADDR,
  input  wire logic [31:0]   PWDATA,
  input  wire logic [3:0]    PSTRB,
  output logic      [31:0]   PRDATA,
  output logic               PREADY,
  output logic               PSLVERR,
  input  wire logic          EN_PIN,
  input  wire logic          VOLTAGE_SELECT_PIN,
  input  wire logic          UVLO_ACTIVE,
  input  wire logic          SW_CYCLE,
  input  wire logic          ILIM_HIT,
  output logic               REG_ON,
  output logic               SS_ACTIVE,
  output logic      [6:0]    SS_REF,
  output logic               SYNC_RECT_EN,
  output logic               SW_TRISTATE,
  output logic               FORCED_PWM,
  output logic      [6:0]    VOUT_CODE,
  output logic      [20:0]   VOUT_UV,
  output logic               DISCHARGE_EN
);
  // ==========================================================
  // Pin synchronisation
  logic [1:0] pins_s;
  logic       en_s;
  logic       voltage_select_pin_s;
  logic       en_d_r;

  bvc_sync #(.WIDTH(2)) u_sync (
    .clk (CORE_CLK),
    .rst (RST),
    .d   ({VOLTAGE_SELECT_PIN, EN_PIN}),
    .q   (pins_s)
  );
  assign en_s   = pins_s[0];
  assign voltage_select_pin_s = pins_s[1];

  // ==========================================================
  // Register file
  logic [7:0] low_slot_voltage_reg_r;
  logic [7:0] high_slot_voltage_reg_r;
  logic [7:0] control_r;
  logic [7:0] monitor;
  logic [7:0] rd_byte;
  logic       acc;
  logic       wr_go;
  logic       hit;
  logic [AW-3:0] idx;

  function automatic logic mapped(input logic [AW-3:0] i);
    mapped = (i <= (AW-2)'(`BVC_IDX_MONITOR));
  endfunction

  assign idx   = PADDR[AW-1:2];
  assign acc   = PSEL && PENABLE && PREADY;
  assign hit   = mapped(idx) && (PADDR[1:0] == 2'b00);
  // Port stays open with the enable pin low; lockout, an unmapped address or PSTRB[0] low refuses writes
  assign wr_go = acc && PWRITE && hit && !UVLO_ACTIVE && PSTRB[0];

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      low_slot_voltage_reg_r  <= `BVC_SLOT_RST | {1'b0, VCODE_RST};
      high_slot_voltage_reg_r <= `BVC_SLOT_RST | {1'b0, VCODE_RST};
      control_r               <= `BVC_CONTROL_RST;
    end else if (wr_go) begin
      if (idx == (AW-2)'(`BVC_IDX_LOW_SLOT))
        low_slot_voltage_reg_r <= PWDATA[7:0];
      if (idx == (AW-2)'(`BVC_IDX_HIGH_SLOT))
        high_slot_voltage_reg_r <= PWDATA[7:0];
      if (idx == (AW-2)'(`BVC_IDX_CONTROL))
        control_r <= PWDATA[7:0];
    end
  end

  always_comb begin
    case (idx)
      (AW-2)'(`BVC_IDX_LOW_SLOT):  rd_byte = low_slot_voltage_reg_r;
      (AW-2)'(`BVC_IDX_HIGH_SLOT): rd_byte = high_slot_voltage_reg_r;
      (AW-2)'(`BVC_IDX_CONTROL):   rd_byte = control_r;
      (AW-2)'(`BVC_IDX_ID1):       rd_byte = ID1_VAL;
      (AW-2)'(`BVC_IDX_ID2):       rd_byte = ID2_VAL;
      (AW-2)'(`BVC_IDX_MONITOR):   rd_byte = monitor;
      default:                     rd_byte = 8'h00;
    endcase
  end

  // One wait state: PREADY rises in the second access cycle
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      PREADY  <= 1'b0;
      PRDATA  <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else begin
      PREADY  <= PSEL && PENABLE && !PREADY;
      PRDATA  <= (PSEL && !PWRITE && hit) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      PSLVERR <= PSEL && PENABLE && !PREADY && (!hit || (PWRITE && UVLO_ACTIVE));
    end
  end

  // ==========================================================
  // Slot selection and mode
  logic       sel_en;
  logic [6:0] sel_code;
  logic       want_on;
  logic [1:0] mode_bits;

  assign sel_en    = voltage_select_pin_s ? high_slot_voltage_reg_r[`BVC_SLOT_EN_BIT]
                            : low_slot_voltage_reg_r[`BVC_SLOT_EN_BIT];
  assign sel_code  = voltage_select_pin_s ? high_slot_voltage_reg_r[6:0]
                            : low_slot_voltage_reg_r[6:0];
  assign mode_bits = control_r[`BVC_CTL_MODE_LSB +: 2];
  assign want_on   = en_s && sel_en && !UVLO_ACTIVE;

  // ==========================================================
  // Enable sequencer
  bvc_state_t state_r;
  bvc_state_t state_nxt;
  logic [4:0] ilim_cnt_r;
  logic [2:0] ss_div_r;
  logic [6:0] ss_ref_nxt;
  logic       trip;
  logic       tmr_done;
  logic       tmr_load;
  logic [31:0] tmr_count;
  logic       active;
  logic       en_rise;

  assign active  = (state_r == BVC_SS) || (state_r == BVC_RUN);
  assign en_rise = en_s && !en_d_r;
  assign trip    = active && SW_CYCLE && ILIM_HIT
                   && (ilim_cnt_r == 5'(`BVC_ILIM_TRIP - 1));

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      BVC_OFF:   if (want_on) state_nxt = (USE_EN_DELAY && en_rise) ? BVC_DELAY
                                                                    : BVC_SS;
      BVC_DELAY: if (tmr_done) state_nxt = BVC_SS;
      BVC_SS:    if (trip) state_nxt = BVC_RETRY;
                 else if (ss_ref_nxt >= sel_code) state_nxt = BVC_RUN;
      BVC_RUN:   if (trip) state_nxt = BVC_RETRY;
      BVC_RETRY: if (tmr_done) state_nxt = BVC_SS;
      default:   state_nxt = BVC_OFF;
    endcase
    if (!want_on) state_nxt = BVC_OFF;
  end

  assign tmr_load  = (state_r == BVC_OFF && state_nxt == BVC_DELAY)
                     || (state_nxt == BVC_RETRY && state_r != BVC_RETRY);
  assign tmr_count = (state_nxt == BVC_DELAY) ? 32'(EN_DELAY_CYC) : 32'(RETRY_CYC);

  bvc_timer #(.W(32)) u_tmr (
    .clk   (CORE_CLK),
    .rst   (RST),
    .load  (tmr_load),
    .count (tmr_count),
    .done  (tmr_done)
  );

  // Reference climbs one code per step so inrush stays bounded
  always_comb begin
    if (state_r == BVC_SS) begin
      ss_ref_nxt = SS_REF;
      if (ss_div_r == 3'(`BVC_SS_STEP_CYC - 1) && SS_REF < sel_code)
        ss_ref_nxt = SS_REF + 7'h01;
    end else if (state_r == BVC_RUN) begin
      ss_ref_nxt = sel_code;
    end else begin
      ss_ref_nxt = 7'h00;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      state_r    <= BVC_OFF;
      en_d_r     <= 1'b0;
      ilim_cnt_r <= 5'h00;
      ss_div_r   <= 3'h0;
    end else begin
      state_r  <= state_nxt;
      en_d_r   <= en_s;
      ss_div_r <= (state_r == BVC_SS) ? ss_div_r + 3'h1 : 3'h0;
      if (!active || trip || (SW_CYCLE && !ILIM_HIT))
        ilim_cnt_r <= 5'h00;
      else if (SW_CYCLE)
        ilim_cnt_r <= ilim_cnt_r + 5'h01;
    end
  end

  assign monitor = {state_r == BVC_RUN, 4'h0, state_r == BVC_RETRY,
                    state_r == BVC_SS, state_r != BVC_OFF};

  // ==========================================================
  // Registered outputs
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      REG_ON       <= 1'b0;
      SS_ACTIVE    <= 1'b0;
      SS_REF       <= 7'h00;
      SYNC_RECT_EN <= 1'b0;
      SW_TRISTATE  <= 1'b1;
      FORCED_PWM   <= 1'b0;
      VOUT_CODE    <= 7'h00;
      VOUT_UV      <= 21'h000000;
      DISCHARGE_EN <= 1'b0;
    end else begin
      REG_ON       <= (state_nxt == BVC_SS) || (state_nxt == BVC_RUN);
      SS_ACTIVE    <= state_nxt == BVC_SS;
      SS_REF       <= ss_ref_nxt;
      SYNC_RECT_EN <= state_nxt == BVC_RUN;
      SW_TRISTATE  <= !((state_nxt == BVC_SS) || (state_nxt == BVC_RUN));
      FORCED_PWM   <= mode_bits[voltage_select_pin_s];
      VOUT_CODE    <= sel_code;
      VOUT_UV      <= 21'(`BVC_VBASE_UV) + 21'(sel_code) * 21'(`BVC_VSTEP_UV);
      DISCHARGE_EN <= control_r[`BVC_CTL_DISCH_BIT] && (!en_s || !sel_en);
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);

  AST_EN_LOW_OFF: assert property (!en_s |=> !REG_ON && SW_TRISTATE)
    else $error("Regulator on with enable low");
  AST_UVLO_WR: assert property (acc && PWRITE && hit && !UVLO_ACTIVE && PSTRB[0]
                                && idx == (AW-2)'(`BVC_IDX_CONTROL)
                                |=> control_r == $past(PWDATA[7:0]))
    else $error("Write not taken with supply above lockout");
  AST_RETAIN: assert property (!wr_go |=> $stable(control_r))
    else $error("Control changed without a write");
  AST_DISCH: assert property (!RST && control_r[7] && !en_s |=> DISCHARGE_EN)
    else $error("Discharge load missing");
  AST_START: assert property (state_r == BVC_OFF && want_on && !USE_EN_DELAY
                              |=> state_r == BVC_SS)
    else $error("Soft-start did not begin");
  AST_SS_NO_SR: assert property (SS_ACTIVE |-> !SYNC_RECT_EN)
    else $error("Rectification during soft-start");
  AST_TRIP: assert property (trip && want_on |=> state_r == BVC_RETRY ##1 SW_TRISTATE)
    else $error("Current-limit trip ignored");
  AST_MODE: assert property (!RST |=> FORCED_PWM == $past(mode_bits[voltage_select_pin_s]))
    else $error("Mode not following select pin");
  AST_VOUT: assert property (!RST |=> VOUT_UV == 21'(350000) + 21'($past(sel_code)) * 21'(6250))
    else $error("Target voltage mismatch");

  CV_RUN:   cover property (state_r == BVC_SS ##[1:1000] state_r == BVC_RUN);
  CV_RETRY: cover property (trip);
  CV_VOLTAGE_SELECT_PIN:  cover property (state_r == BVC_RUN && $changed(voltage_select_pin_s));
endmodule

// ===== src/bvc_defines.svh
/*
  Constants of the buck enable and voltage-select control: register indices,
  field positions, reset values and timing counts.
  Assumes a 125 MHz core clock and APB word addressing (byte address = 4 x index).
*/
`ifndef BVC_DEFINES_SVH
`define BVC_DEFINES_SVH

// ==========================================================
// Register indices (byte address is four times the index)
`define BVC_IDX_LOW_SLOT  8'h00
`define BVC_IDX_HIGH_SLOT 8'h01
`define BVC_IDX_CONTROL   8'h02
`define BVC_IDX_ID1       8'h03
`define BVC_IDX_ID2       8'h04
`define BVC_IDX_MONITOR   8'h05

// ==========================================================
// Field positions
`define BVC_SLOT_EN_BIT   7
`define BVC_CTL_DISCH_BIT 7
`define BVC_CTL_SLEW_LSB  4
`define BVC_CTL_MODE_LSB  0

// ==========================================================
// Reset values
`define BVC_SLOT_RST      8'hC0
`define BVC_CONTROL_RST   8'h82

// ==========================================================
// Timing and arithmetic
`define BVC_CLK_MHZ       125
`define BVC_EN_DELAY_US   5000
`define BVC_RETRY_US      1700
`define BVC_EN_DELAY_CYC  (`BVC_EN_DELAY_US * `BVC_CLK_MHZ)
`define BVC_RETRY_CYC     (`BVC_RETRY_US * `BVC_CLK_MHZ)
`define BVC_ILIM_TRIP     16
`define BVC_SS_STEP_CYC   8
`define BVC_VBASE_UV      350000
`define BVC_VSTEP_UV      6250

`endif

// ===== src/bvc_pkg.sv
/*
  Types of the buck enable and voltage-select control.
  Assumes nothing beyond the defines header.
*/
package bvc_pkg;
  typedef enum logic [2:0] {
    BVC_OFF   = 3'b000,
    BVC_DELAY = 3'b001,
    BVC_SS    = 3'b010,
    BVC_RUN   = 3'b011,
    BVC_RETRY = 3'b100
  } bvc_state_t;
endpackage

// ===== src/bvc_sync.sv
/*
  Two-flop synchroniser for a group of pin levels.
  Assumes the inputs are quasi-static levels; each bit is treated alone.
*/
`timescale 1ns/1ps
module bvc_sync #(
  parameter int WIDTH = 2
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_r;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clk) begin
        if (rst) begin
          meta_r[i] <= 1'b0;
          q[i]      <= 1'b0;
        end else begin
          meta_r[i] <= d[i];
          q[i]      <= meta_r[i];
        end
      end
    end
  endgenerate
endmodule

// ===== src/bvc_timer.sv
/*
  Loadable down counter giving a one-cycle done pulse.
  Assumes load is a single-cycle pulse; a new load restarts the count.
*/
`timescale 1ns/1ps
module bvc_timer #(
  parameter int W = 20
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         load,
  input  wire logic [W-1:0] count,
  output logic              done
);
  logic [W-1:0] cnt_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_r <= '0;
    end else if (load) begin
      cnt_r <= count;
    end else if (cnt_r != '0) begin
      cnt_r <= cnt_r - W'(1);
    end
  end

  assign done = (cnt_r == W'(1)) && !load;
endmodule

// ===== tb/bvc_host.sv
/*
  APB master model standing in for the host controller.
  Assumes one go pulse per transfer, given only while no transfer is open.
*/
`timescale 1ns/1ps
module bvc_host (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        go,
  input  wire logic        wr,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  input  wire logic        pslverr,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  output logic [31:0]      rdata,
  output logic             err,
  output logic             done
);
  initial begin
    {psel, penable, pwrite, err, done} = 5'h00;
    paddr  = 8'h00;
    pwdata = 32'h0;
    rdata  = 32'h0;
  end
  // ==========================================================
  // Transfer sequencing
  always @(posedge clk) begin
    done <= !rst && psel && penable && pready;
    if (rst) begin
      psel    <= 1'b0;
      penable <= 1'b0;
    end else if (!psel && go) begin
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= addr;
      pwdata <= wdata;
    end else if (psel && !penable) begin
      penable <= 1'b1;
    end else if (psel && pready) begin
      rdata   <= prdata;
      err     <= pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      // Released lines must not keep the old value
      paddr   <= ~paddr;
      pwdata  <= ~pwdata;
    end
  end
endmodule

// ===== tb/testbench.sv
/*
  Self-checking bench of the buck enable and voltage-select control.
  Assumes the host model drives APB and shortened retry and delay counts.
*/
`timescale 1ns/1ps
module testbench;
  localparam int RETRY = 30;
  logic        clk = 1'b0, rst = 1'b1, go = 1'b0, wr = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0, rnd = 32'h00014A8A;
  logic        en_pin = 1'b0, voltage_select_pin = 1'b0, uvlo = 1'b0, sw_cyc = 1'b0, ilim = 1'b0;
  logic        psel, penable, pwrite, pready, pslverr, err, done;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic        reg_on, ss_act, sync_rect, tristate, forced_pwm, disch, dly_on;
  logic [6:0]  ss_ref, vcode;
  logic [20:0] vuv;
  int          err_count = 0, compares = 0;
  always #4 clk = ~clk;
  // ==========================================================
  // Instances
  bvc_host host_u (.clk(clk), .rst(rst), .go(go), .wr(wr), .addr(addr), .wdata(wdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .rdata(rdata), .err(err), .done(done));
  bvc_top #(.EN_DELAY_CYC(20), .RETRY_CYC(RETRY)) dut_u (.CORE_CLK(clk), .RST(rst),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PSTRB(4'hF), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .EN_PIN(en_pin),
    .VOLTAGE_SELECT_PIN(voltage_select_pin), .UVLO_ACTIVE(uvlo), .SW_CYCLE(sw_cyc), .ILIM_HIT(ilim),
    .REG_ON(reg_on), .SS_ACTIVE(ss_act), .SS_REF(ss_ref), .SYNC_RECT_EN(sync_rect),
    .SW_TRISTATE(tristate), .FORCED_PWM(forced_pwm), .VOUT_CODE(vcode), .VOUT_UV(vuv),
    .DISCHARGE_EN(disch));
  // Delayed-start build option, register port idle, sharing the pins
  bvc_top #(.USE_EN_DELAY(1'b1), .EN_DELAY_CYC(20), .RETRY_CYC(RETRY)) dly_u (
    .CORE_CLK(clk), .RST(rst), .PSEL(1'b0), .PENABLE(1'b0), .PWRITE(1'b0), .PADDR(8'h00),
    .PWDATA(32'h0), .PSTRB(4'h0), .PRDATA(), .PREADY(), .PSLVERR(), .EN_PIN(en_pin),
    .VOLTAGE_SELECT_PIN(voltage_select_pin), .UVLO_ACTIVE(1'b0), .SW_CYCLE(1'b0), .ILIM_HIT(1'b0),
    .REG_ON(dly_on), .SS_ACTIVE(), .SS_REF(), .SYNC_RECT_EN(), .SW_TRISTATE(),
    .FORCED_PWM(), .VOUT_CODE(), .VOUT_UV(), .DISCHARGE_EN());
  // ==========================================================
  // Helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] uv(input logic [6:0] c);
    return 32'd350000 + {25'h0, c} * 32'd6250;
  endfunction
  function automatic logic sig(input int s);
    case (s)
      0:       return reg_on;
      1:       return sync_rect;
      default: return tristate;
    endcase
  endfunction
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  task automatic finish_test;
    $display("mismatches %0d comparisons %0d", err_count, compares);
    if (err_count == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    go    <= 1'b1;
    wr    <= w;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    go <= 1'b0;
    while (done !== 1'b1 && n < 50) begin
      @(negedge clk);
      n++;
    end
    chk("apb done", 32'h1, {31'h0, done});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic e);
    apb(1'b0, a, 32'h0);
    chk("rdata", exp, rdata);
    chk("pslverr", {31'h0, e}, {31'h0, err});
  endtask
  task automatic waitfor(input int s, input logic v, output int n);
    n = 0;
    while (sig(s) !== v && n < 2000) begin
      @(negedge clk);
      n++;
    end
    chk("level", {31'h0, v}, {31'h0, sig(s)});
  endtask
  task automatic pulses(input int k, input logic h);
    repeat (k) begin
      @(posedge clk);
      sw_cyc <= 1'b1;
      ilim   <= h;
      @(posedge clk);
      sw_cyc <= 1'b0;
    end
  endtask
  initial begin
    #(60000 * 8);
    err_count++;
    finish_test();
  end
  // ==========================================================
  // Main sequence
  initial begin
    int n;
    logic [6:0] c0, c1, c;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    rd(8'h00, 32'hC0, 1'b0);
    rd(8'h04, 32'hC0, 1'b0);
    rd(8'h08, 32'h82, 1'b0);
    rd(8'h18, 32'h0, 1'b1);
    chk("reg_on", 32'h0, {31'h0, reg_on});
    chk("discharge", 32'h1, {31'h0, disch});
    rnd = lfsr(rnd);
    c0 = {2'b00, rnd[4:0]} + 7'd1;
    c1 = c0 ^ 7'h20;
    apb(1'b1, 8'h00, {24'h0, 1'b1, c0});
    apb(1'b1, 8'h04, {24'h0, 1'b1, c1});
    rd(8'h00, {24'h0, 1'b1, c0}, 1'b0);
    @(posedge clk) uvlo <= 1'b1;
    apb(1'b1, 8'h08, 32'h0);
    chk("uvlo write", 32'h1, {31'h0, err});
    @(posedge clk) uvlo <= 1'b0;
    rd(8'h08, 32'h82, 1'b0);
    @(posedge clk) en_pin <= 1'b1;
    waitfor(0, 1'b1, n);
    chk("sync delay", 32'h1, {31'h0, n >= 2 && n <= 6});
    chk("soft-start", 32'h1, {31'h0, ss_act});
    chk("no rectify", 32'h0, {31'h0, sync_rect});
    chk("delay hold", 32'h0, {31'h0, dly_on});
    waitfor(1, 1'b1, n);
    chk("ramp length", 32'h1, {31'h0, n >= 8 * (int'(c0) - 1)});
    chk("ss_ref", {25'h0, c0}, {25'h0, ss_ref});
    chk("vcode", {25'h0, c0}, {25'h0, vcode});
    chk("vout", uv(c0), {11'h0, vuv});
    chk("forced_pwm", 32'h0, {31'h0, forced_pwm});
    chk("discharge", 32'h0, {31'h0, disch});
    @(posedge clk) voltage_select_pin <= 1'b1;
    repeat (4) @(negedge clk);
    chk("vcode", {25'h0, c1}, {25'h0, vcode});
    chk("forced_pwm", 32'h1, {31'h0, forced_pwm});
    pulses(15, 1'b1);
    pulses(1, 1'b0);
    pulses(15, 1'b1);
    repeat (2) @(negedge clk);
    chk("still on", 32'h1, {31'h0, reg_on});
    chk("delayed on", 32'h1, {31'h0, dly_on});
    pulses(1, 1'b1);
    waitfor(2, 1'b1, n);
    chk("tripped", 32'h0, {31'h0, reg_on});
    waitfor(2, 1'b0, n);
    chk("retry span", 32'h1, {31'h0, n >= RETRY - 2 && n <= RETRY + 6});
    chk("restart", 32'h1, {31'h0, ss_act});
    waitfor(1, 1'b1, n);
    rd(8'h14, 32'h81, 1'b0);
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      c = (i == 0) ? 7'h7F : rnd[6:0];
      apb(1'b1, 8'h04, {24'h0, 1'b1, c});
      repeat (3) @(negedge clk);
      chk("vcode", {25'h0, c}, {25'h0, vcode});
      chk("vout", uv(c), {11'h0, vuv});
    end
    apb(1'b1, 8'h04, {24'h0, 1'b0, c1});
    waitfor(0, 1'b0, n);
    chk("discharge", 32'h1, {31'h0, disch});
    apb(1'b1, 8'h08, 32'h01);
    repeat (3) @(negedge clk);
    chk("discharge", 32'h0, {31'h0, disch});
    chk("forced_pwm", 32'h0, {31'h0, forced_pwm});
    @(posedge clk) voltage_select_pin <= 1'b0;
    waitfor(0, 1'b1, n);
    chk("forced_pwm", 32'h1, {31'h0, forced_pwm});
    @(posedge clk) en_pin <= 1'b0;
    waitfor(0, 1'b0, n);
    rd(8'h00, {24'h0, 1'b1, c0}, 1'b0);
    rd(8'h04, {24'h0, 1'b0, c1}, 1'b0);
    @(posedge clk) rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    rd(8'h00, 32'hC0, 1'b0);
    rd(8'h08, 32'h82, 1'b0);
    finish_test();
  end
endmodule
